/* design/pwm_ctl_pkg.sv */
package pwm_ctl_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_MASTER_CTL = 12'h000;
    localparam logic [11:0] OFS_SYNC_REQ = 12'h004;
    localparam logic [11:0] OFS_PIN_EN = 12'h008;
    localparam logic [11:0] OFS_INVERT = 12'h00c;
    localparam logic [11:0] OFS_FAULT = 12'h010;
    localparam logic [11:0] OFS_INT_EN = 12'h014;
    localparam logic [11:0] OFS_RAW_INT = 12'h018;
    localparam logic [11:0] OFS_INT_CLR = 12'h01c;
    localparam logic [11:0] OFS_FAULT_LVL = 12'h020;
    localparam logic [11:0] OFS_GEN_CTL = 12'h040;
    localparam logic [11:0] OFS_GEN_INTEN = 12'h044;
    localparam logic [11:0] OFS_GEN_RIS = 12'h048;
    localparam logic [11:0] OFS_GEN_ISC = 12'h04c;
    localparam logic [11:0] OFS_LOAD = 12'h050;
    localparam logic [11:0] OFS_COUNT = 12'h054;
    localparam logic [11:0] OFS_CMPA = 12'h058;
    localparam logic [11:0] OFS_CMPB = 12'h05c;
    localparam logic [11:0] OFS_ACT_A = 12'h060;
    localparam logic [11:0] OFS_ACT_B = 12'h064;
    localparam logic [11:0] OFS_DB_CTL = 12'h068;
    localparam logic [11:0] OFS_DB_RISE = 12'h06c;
    localparam logic [11:0] OFS_DB_FALL = 12'h070;
    // field positions
    localparam int GC_RUN = 0;
    localparam int GC_UPDOWN = 1;
    localparam int GC_DBG_RUN = 2;
    localparam int GC_LOAD_SYNC = 3;
    localparam int GC_CMPA_SYNC = 4;
    localparam int GC_CMPB_SYNC = 5;
    localparam int IE_GEN = 0;
    localparam int IE_FAULT = 16;
    localparam int TRG_POS = 8;
    localparam int EV_ZERO = 0;
    localparam int EV_LOAD = 1;
    localparam int EV_AUP = 2;
    localparam int EV_ADN = 3;
    localparam int EV_BUP = 4;
    localparam int EV_BDN = 5;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [5:0] RST_EV = 6'h00;
    localparam logic [1:0] RST_PAIR = 2'h0;
endpackage

/* design/pwm_ctl.sv */
// Overview of operation
// - selected counter events, any subset, raise the generator interrupt.
// - separate event selection emits a converter trigger pulse.
// - interrupts and triggers use raw counter events, not dead-band edges.
// - sync request resets the one counter to zero on one edge.
// - immediate mode applies new load and compare values at counter zero.
// - sync mode waits for global update, then applies all at zero.
// - fault input and debugger halt both count as fault conditions.
// - per-output fault bit forces that output inactive during a fault.
// - detected fault input can raise a processor interrupt.
// - debug halt either keeps counting or runs to zero and stops.
// - debug stall never raises any interrupt.
// - one enable register gates which raw signals reach the pins.
// - optional per-output inversion is the final stage.
// - control zero is down, immediate, stopped; bit zero starts counter.
// - module registers at 0x000-0x020, generator at 0x040-0x070.
// - fault level readable; interrupt status cleared by writing ones.
// - disabled output becomes zero, still passed through inversion.
// - fault forcing precedes inversion.
// - global update bit self-clears after updates; software cannot clear.
module pwm_ctl
    import pwm_ctl_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // external conditions
    input wire logic i_fault,
    input wire logic i_debug_halt,
    // waveform and dead-band block
    input wire logic i_raw_output_pin_zero,
    input wire logic i_raw_output_pin_one,
    output logic [15:0] o_count,
    output logic o_dir_up,
    output logic [5:0] o_events,
    output logic [15:0] o_cmpa,
    output logic [15:0] o_cmpb,
    output logic [31:0] o_act_a,
    output logic [31:0] o_act_b,
    output logic [31:0] o_db_ctl,
    output logic [31:0] o_db_rise,
    output logic [31:0] o_db_fall,
    // pins, trigger, interrupt
    output logic o_pin0,
    output logic o_pin1,
    output logic o_adc_trigger,
    output logic o_irq
);
    logic [31:0] gen_ctl_r, gen_inten_r, load_r, cmpa_r, cmpb_r;
    logic [31:0] act_a_r, act_b_r, db_ctl_r, db_rise_r, db_fall_r;
    logic [15:0] load_act_r, cmpa_act_r, cmpb_act_r, count_r;
    logic [1:0] pin_en_r, inv_r, fault_en_r;
    logic [31:0] inten_r, rdata_r, rd_val;
    logic [5:0] gen_ris_r, ev;
    logic gup_r, sync_r, dir_r, stopped_r, fault_m_r, fault_s_r;
    logic fault_lat_r, trig_r, pin0_r, pin1_r;
    logic adv, at_zero, halt_stop, fault_cond, gen_int, wr_gen_ctl;
    logic [1:0] stage, forced;
    logic [31:0] mod_ris;

    function automatic logic wr_at(input logic [11:0] a);
        wr_at = i_wr && (i_addr == a);
    endfunction

    // register writes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin_en_r <= RST_PAIR;
            inv_r <= RST_PAIR;
            fault_en_r <= RST_PAIR;
            inten_r <= RST_WORD;
            gen_ctl_r <= RST_WORD;
            gen_inten_r <= RST_WORD;
            load_r <= RST_WORD;
            cmpa_r <= RST_WORD;
            cmpb_r <= RST_WORD;
            act_a_r <= RST_WORD;
            act_b_r <= RST_WORD;
            db_ctl_r <= RST_WORD;
            db_rise_r <= RST_WORD;
            db_fall_r <= RST_WORD;
        end else begin
            if (wr_at(OFS_PIN_EN)) pin_en_r <= i_wdata[1:0];
            if (wr_at(OFS_INVERT)) inv_r <= i_wdata[1:0];
            if (wr_at(OFS_FAULT)) fault_en_r <= i_wdata[1:0];
            if (wr_at(OFS_INT_EN)) begin
                inten_r <= i_wdata & 32'h0001_0001;
            end
            // all zero: down count, immediate updates, stopped
            if (wr_at(OFS_GEN_CTL)) gen_ctl_r <= i_wdata & 32'h0000_003f;
            if (wr_at(OFS_GEN_INTEN)) begin
                gen_inten_r <= i_wdata & 32'h0000_3f3f;
            end
            if (wr_at(OFS_LOAD)) load_r <= {16'h0000, i_wdata[15:0]};
            if (wr_at(OFS_CMPA)) cmpa_r <= {16'h0000, i_wdata[15:0]};
            if (wr_at(OFS_CMPB)) cmpb_r <= {16'h0000, i_wdata[15:0]};
            if (wr_at(OFS_ACT_A)) act_a_r <= i_wdata;
            if (wr_at(OFS_ACT_B)) act_b_r <= i_wdata;
            if (wr_at(OFS_DB_CTL)) db_ctl_r <= i_wdata;
            if (wr_at(OFS_DB_RISE)) db_rise_r <= i_wdata;
            if (wr_at(OFS_DB_FALL)) db_fall_r <= i_wdata;
        end
    end

    assign wr_gen_ctl = i_wr && (i_addr == OFS_MASTER_CTL) && i_wdata[0];
    assign at_zero = (count_r == RST_HALF);

    // raw counter events, ahead of any dead-band delay
    always_comb begin
        ev = RST_EV;
        if (gen_ctl_r[GC_RUN] && !stopped_r) begin
            ev[EV_ZERO] = at_zero;
            ev[EV_LOAD] = (count_r == load_act_r);
            if (!ev[EV_ZERO] && !ev[EV_LOAD]) begin
                if (cmpa_act_r <= load_act_r && count_r == cmpa_act_r) begin
                    ev[EV_AUP] = dir_r;
                    ev[EV_ADN] = !dir_r;
                end
                if (cmpb_act_r <= load_act_r && count_r == cmpb_act_r) begin
                    ev[EV_BUP] = dir_r;
                    ev[EV_BDN] = !dir_r;
                end
            end
        end
    end

    // run-to-zero stall: freeze at zero while halted
    assign halt_stop = i_debug_halt && !gen_ctl_r[GC_DBG_RUN];
    assign adv = gen_ctl_r[GC_RUN] && !stopped_r && !(halt_stop && at_zero);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stopped_r <= 1'b0;
        end else begin
            stopped_r <= halt_stop && (stopped_r || at_zero);
        end
    end

    // counter sync bit self-clears after one reset cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync_r <= 1'b0;
        end else begin
            sync_r <= wr_at(OFS_SYNC_REQ) && i_wdata[0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_r <= RST_HALF;
            dir_r <= 1'b0;
        end else if (sync_r) begin
            count_r <= RST_HALF;
            dir_r <= gen_ctl_r[GC_UPDOWN];
        end else if (adv) begin
            if (!gen_ctl_r[GC_UPDOWN]) begin
                dir_r <= 1'b0;
                // period is load plus one ticks
                count_r <= at_zero ? load_act_r : count_r - 16'h0001;
            end else if (dir_r) begin
                if (count_r >= load_act_r) begin
                    dir_r <= 1'b0;
                    count_r <= at_zero ? count_r : count_r - 16'h0001;
                end else begin
                    count_r <= count_r + 16'h0001;
                end
            end else if (at_zero) begin
                dir_r <= 1'b1;
                if (load_act_r != RST_HALF) count_r <= 16'h0001;
            end else begin
                count_r <= count_r - 16'h0001;
            end
        end
    end

    // active values change only at zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            load_act_r <= RST_HALF;
            cmpa_act_r <= RST_HALF;
            cmpb_act_r <= RST_HALF;
        end else if (ev[EV_ZERO]) begin
            if (!gen_ctl_r[GC_LOAD_SYNC] || gup_r) begin
                load_act_r <= load_r[15:0];
            end
            if (!gen_ctl_r[GC_CMPA_SYNC] || gup_r) begin
                cmpa_act_r <= cmpa_r[15:0];
            end
            if (!gen_ctl_r[GC_CMPB_SYNC] || gup_r) begin
                cmpb_act_r <= cmpb_r[15:0];
            end
        end
    end

    // global update: set by software, cleared only by hardware
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            gup_r <= 1'b0;
        end else if (wr_gen_ctl) begin
            gup_r <= 1'b1;
        end else if (ev[EV_ZERO]) begin
            gup_r <= 1'b0;
        end
    end

    // generator event status, set wins over clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            gen_ris_r <= RST_EV;
        end else begin
            gen_ris_r <= (gen_ris_r & ~({6{wr_at(OFS_GEN_ISC)}} &
                i_wdata[5:0])) | (ev & gen_inten_r[5:0]);
        end
    end
    assign gen_int = |(gen_ris_r & gen_inten_r[5:0]);

    // trigger pulse one cycle after its event
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            trig_r <= 1'b0;
        end else begin
            trig_r <= |(ev & gen_inten_r[TRG_POS+5:TRG_POS]);
        end
    end

    // two-stage synchroniser on the fault pin
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            fault_m_r <= 1'b0;
            fault_s_r <= 1'b0;
        end else begin
            fault_m_r <= i_fault;
            fault_s_r <= fault_m_r;
        end
    end

    // only the pin latches, halts never interrupt
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            fault_lat_r <= 1'b0;
        end else if (fault_s_r) begin
            fault_lat_r <= 1'b1;
        end else if (wr_at(OFS_INT_CLR) && i_wdata[IE_FAULT]) begin
            fault_lat_r <= 1'b0;
        end
    end

    assign fault_cond = fault_s_r || i_debug_halt;
    assign stage = {i_raw_output_pin_one, i_raw_output_pin_zero} & pin_en_r;
    assign forced = stage & ~({2{fault_cond}} & fault_en_r);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pin0_r <= 1'b0;
            pin1_r <= 1'b0;
        end else begin
            pin0_r <= forced[0] ^ inv_r[0];
            pin1_r <= forced[1] ^ inv_r[1];
        end
    end

    always_comb begin
        mod_ris = RST_WORD;
        mod_ris[IE_GEN] = gen_int;
        mod_ris[IE_FAULT] = fault_lat_r;
    end

    // read mux, unmapped reads zero
    always_comb begin
        rd_val = RST_WORD;
        unique case (i_addr)
            OFS_MASTER_CTL: rd_val = {31'h0, gup_r};
            OFS_SYNC_REQ: rd_val = {31'h0, sync_r};
            OFS_PIN_EN: rd_val = {30'h0, pin_en_r};
            OFS_INVERT: rd_val = {30'h0, inv_r};
            OFS_FAULT: rd_val = {30'h0, fault_en_r};
            OFS_INT_EN: rd_val = inten_r;
            OFS_RAW_INT: rd_val = mod_ris;
            OFS_INT_CLR: rd_val = mod_ris & inten_r;
            OFS_FAULT_LVL: rd_val = {31'h0, fault_s_r};
            OFS_GEN_CTL: rd_val = gen_ctl_r;
            OFS_GEN_INTEN: rd_val = gen_inten_r;
            OFS_GEN_RIS: rd_val = {26'h0, gen_ris_r};
            OFS_GEN_ISC: rd_val = {26'h0, gen_ris_r & gen_inten_r[5:0]};
            OFS_LOAD: rd_val = load_r;
            OFS_COUNT: rd_val = {16'h0, count_r};
            OFS_CMPA: rd_val = cmpa_r;
            OFS_CMPB: rd_val = cmpb_r;
            OFS_ACT_A: rd_val = act_a_r;
            OFS_ACT_B: rd_val = act_b_r;
            OFS_DB_CTL: rd_val = db_ctl_r;
            OFS_DB_RISE: rd_val = db_rise_r;
            OFS_DB_FALL: rd_val = db_fall_r;
            default: rd_val = RST_WORD;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_r <= RST_WORD;
        end else begin
            rdata_r <= i_rd ? rd_val : RST_WORD;
        end
    end

    assign o_rdata = rdata_r;
    assign o_count = count_r;
    assign o_dir_up = dir_r;
    assign o_events = ev;
    assign o_cmpa = cmpa_act_r;
    assign o_cmpb = cmpb_act_r;
    assign o_act_a = act_a_r;
    assign o_act_b = act_b_r;
    assign o_db_ctl = db_ctl_r;
    assign o_db_rise = db_rise_r;
    assign o_db_fall = db_fall_r;
    assign o_pin0 = pin0_r;
    assign o_pin1 = pin1_r;
    assign o_adc_trigger = trig_r;
    assign o_irq = |(mod_ris & inten_r);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_sync_write;
        i_wr && i_addr == OFS_SYNC_REQ && i_wdata[0];
    endsequence
    sequence s_sync_done;
        sync_r ##1 (count_r == RST_HALF && !sync_r);
    endsequence

    a_sync_counter_reset: assert property (
        s_sync_write |=> s_sync_done)
        else $error("sync request did not zero the counter");
    a_immediate_load_upd: assert property (
        ev[EV_ZERO] && !gen_ctl_r[GC_LOAD_SYNC]
        |=> load_act_r == $past(load_r[15:0]))
        else $error("immediate load value not applied at zero");
    a_active_hold_zero: assert property (
        !ev[EV_ZERO] |=> $stable(load_act_r) && $stable(cmpa_act_r))
        else $error("active values changed away from zero");
    a_global_upd_clear: assert property (
        gup_r && ev[EV_ZERO] && !wr_gen_ctl |=> !gup_r)
        else $error("global update bit not cleared after apply");
    a_fault_forces_pin: assert property (
        fault_cond && fault_en_r[0] |=> o_pin0 == $past(inv_r[0]))
        else $error("faulted output not forced inactive");
    a_disabled_pin_idle: assert property (
        !pin_en_r[1] |=> o_pin1 == $past(inv_r[1]))
        else $error("disabled output not idle at its polarity");
    a_trigger_pulse: assert property (
        (ev & gen_inten_r[TRG_POS+5:TRG_POS]) != RST_EV |=> o_adc_trigger)
        else $error("selected event gave no trigger");
    a_gen_event_latch: assert property (
        ev[EV_ZERO] && gen_inten_r[EV_ZERO] |=> gen_ris_r[EV_ZERO] ##0 o_irq
        || !inten_r[IE_GEN])
        else $error("selected event not latched");
    a_halt_no_irq: assert property (
        !fault_s_r && !fault_lat_r |=> !fault_lat_r)
        else $error("fault latch set without fault input");
    a_fault_sticky: assert property (
        fault_lat_r && !(i_wr && i_addr == OFS_INT_CLR) |=> fault_lat_r)
        else $error("fault latch lost without clear");
    a_fault_sync_delay: assert property (
        i_fault ##1 i_fault |=> fault_s_r)
        else $error("fault input not seen after two stages");
    a_stop_at_zero: assert property (
        stopped_r |-> at_zero && ev == RST_EV)
        else $error("stalled counter not held at zero");
endmodule

/* bench/pwm_stage_model.sv */
module pwm_stage_model (
    // clock
    input wire logic i_clock,
    // counter view
    input wire logic [15:0] i_count,
    input wire logic [15:0] i_cmpa,
    input wire logic [15:0] i_cmpb,
    // bench control of the raw levels
    input wire logic i_hold,
    input wire logic i_lvl0,
    input wire logic i_lvl1,
    // converter trigger
    input wire logic i_trigger,
    output logic o_raw0,
    output logic o_raw1,
    output logic [15:0] o_trig_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    // crude waveform stage; hold lets the bench pin the levels
    assign o_raw0 = i_hold ? i_lvl0 : (i_count < i_cmpa);
    assign o_raw1 = i_hold ? i_lvl1 : (i_count < i_cmpb);
    // counts high cycles, since adjacent pulses merge into one level
    logic [15:0] trig_cnt = 16'h0000;
    assign o_trig_cycles = trig_cnt;
    always @(posedge i_clock) begin
        if (i_trigger === 1'b1) trig_cnt <= trig_cnt + 16'h0001;
    end
endmodule

/* bench/tb_top.sv */
module tb_top import pwm_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_fault = 1'b0;
    logic i_debug_halt = 1'b0;
    logic hold = 1'b1;
    logic lvl0 = 1'b0;
    logic lvl1 = 1'b0;
    logic raw0, raw1, pin0, pin1, trig, irq;
    logic [15:0] cnt, cmpa, cmpb, trig_cyc, c;
    logic [5:0] ev;
    logic [31:0] rdata, d;
    logic [31:0] act_a, act_b, db_ctl, db_rise, db_fall;
    logic dir_up;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    always #12.5 i_clock = ~i_clock;

    pwm_ctl uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_fault(i_fault), .i_debug_halt(i_debug_halt), .i_raw_output_pin_zero(raw0),
        .i_raw_output_pin_one(raw1), .o_count(cnt), .o_dir_up(dir_up), .o_events(ev),
        .o_cmpa(cmpa), .o_cmpb(cmpb), .o_act_a(act_a), .o_act_b(act_b),
        .o_db_ctl(db_ctl), .o_db_rise(db_rise), .o_db_fall(db_fall),
        .o_pin0(pin0), .o_pin1(pin1),
        .o_adc_trigger(trig), .o_irq(irq));

    pwm_stage_model stage (.i_clock(i_clock), .i_count(cnt), .i_cmpa(cmpa),
        .i_cmpb(cmpb), .i_hold(hold), .i_lvl0(lvl0), .i_lvl1(lvl1),
        .i_trigger(trig), .o_raw0(raw0), .o_raw1(raw1),
        .o_trig_cycles(trig_cyc));

    task automatic summarize();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // whole run needs well under 5000 cycles
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        // data stand only in the cycle after the strobe
        @(posedge i_clock);
        v = rdata;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(d, exp, "register read");
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    task automatic t_map();
        logic [11:0] ofs [3];
        ofs = '{OFS_PIN_EN, OFS_INVERT, OFS_FAULT};
        // unmapped holes between 0x024 and 0x03c read zero as well
        for (int a = 0; a <= 'h70; a += 4) rchk(a[11:0], RST_WORD);
        rchk(12'h100, RST_WORD);
        foreach (ofs[i]) begin
            wr(ofs[i], 32'hffff_ffff);
            rchk(ofs[i], 32'h0000_0003);
            wr(ofs[i], 32'h0000_0000);
        end
        wr(OFS_COUNT, 32'h0000_0005);
        rchk(OFS_COUNT, 32'h0000_0000);
        wr(OFS_RAW_INT, 32'hffff_ffff);
        rchk(OFS_RAW_INT, 32'h0000_0000);
        wr(12'h080, 32'hffff_ffff);
        rchk(12'h080, 32'h0000_0000);
        wr(OFS_ACT_A, 32'h1111_0001);
        wr(OFS_ACT_B, 32'h2222_0002);
        wr(OFS_DB_CTL, 32'h3333_0003);
        wr(OFS_DB_RISE, 32'h4444_0004);
        wr(OFS_DB_FALL, 32'h5555_0005);
        cyc(1);
        chk(act_a, 32'h1111_0001, "action a copy");
        chk(act_b, 32'h2222_0002, "action b copy");
        chk(db_ctl, 32'h3333_0003, "dead-band control copy");
        chk(db_rise, 32'h4444_0004, "rise delay copy");
        chk(db_fall, 32'h5555_0005, "fall delay copy");
        rchk(OFS_DB_FALL, 32'h5555_0005);
    endtask

    task automatic t_pins();
        logic e;
        // both sources enabled, so a halt-raised irq would show
        wr(OFS_INT_EN, 32'h0001_0001);
        for (int i = 0; i < 32; i++) begin
            wr(OFS_PIN_EN, {30'h0, i[1], i[1]});
            wr(OFS_INVERT, {30'h0, i[2], i[2]});
            wr(OFS_FAULT, {30'h0, i[3], i[3]});
            lvl0 <= i[0];
            lvl1 <= ~i[0];
            i_debug_halt <= i[4];
            cyc(3);
            e = ((i[0] & i[1]) & ~(i[4] & i[3])) ^ i[2];
            chk(pin0, e, "pin zero");
            e = ((~i[0] & i[1]) & ~(i[4] & i[3])) ^ i[2];
            chk(pin1, e, "pin one");
            chk(irq, 1'b0, "halt irq");
        end
        i_debug_halt <= 1'b0;
        wr(OFS_FAULT, 32'h0);
        wr(OFS_INVERT, 32'h0);
    endtask

    task automatic t_events(input logic up, input logic [5:0] sel,
                            input int exp);
        wr(OFS_CMPA, 32'h0000_0002);
        wr(OFS_LOAD, 32'h0000_0004);
        wr(OFS_GEN_INTEN, {18'h0, sel, 2'h0, sel});
        wr(OFS_INT_EN, 32'h0000_0001);
        wr(OFS_GEN_CTL, {30'h0, up, 1'b1});
        cyc(10);
        c = trig_cyc;
        cyc(40);
        chk(trig_cyc - c, exp, "trigger cycles");
        chk(irq, 1'b1, "gen irq");
        wr(OFS_GEN_CTL, 32'h0);
        chk(dir_up, up, "direction");
        rd(OFS_GEN_RIS, d);
        chk(d & {26'h0, sel}, {26'h0, sel}, "gen flags");
        wr(OFS_GEN_ISC, 32'h0000_003f);
        cyc(1);
        chk(irq, 1'b0, "gen irq cleared");
        c = cnt;
        cyc(5);
        chk(cnt, c, "stopped counter");
        wr(OFS_SYNC_REQ, 32'h0000_0001);
        cyc(3);
        chk(cnt, 16'h0000, "sync reset");
        rchk(OFS_SYNC_REQ, 32'h0);
    endtask

    task automatic t_update();
        wr(OFS_CMPA, 32'h0000_0001);
        wr(OFS_CMPB, 32'h0000_0003);
        cyc(5);
        chk(cmpa, 16'h0002, "held while stopped");
        wr(OFS_GEN_CTL, 32'h0000_0001);
        cyc(10);
        chk(cmpa, 16'h0001, "applied at zero");
        chk(cmpb, 16'h0003, "b applied at zero");
        wr(OFS_GEN_CTL, 32'h1 | (32'h1 << GC_CMPA_SYNC));
        wr(OFS_CMPA, 32'h0000_0003);
        cyc(20);
        chk(cmpa, 16'h0001, "waits for global");
        wr(OFS_GEN_CTL, 32'h1 << GC_CMPA_SYNC);
        wr(OFS_MASTER_CTL, 32'h0000_0001);
        wr(OFS_MASTER_CTL, 32'h0000_0000);
        rchk(OFS_MASTER_CTL, 32'h0000_0001);
        wr(OFS_GEN_CTL, 32'h1 | (32'h1 << GC_CMPA_SYNC));
        cyc(10);
        chk(cmpa, 16'h0003, "global applied");
        rchk(OFS_MASTER_CTL, 32'h0);
    endtask

    task automatic t_stall();
        wr(OFS_GEN_INTEN, 32'h0);
        wr(OFS_INT_EN, 32'h1 << IE_FAULT);
        wr(OFS_GEN_CTL, 32'h0000_0001);
        i_debug_halt <= 1'b1;
        cyc(10);
        chk(cnt, 16'h0000, "stall at zero");
        cyc(3);
        chk(cnt, 16'h0000, "still stalled");
        chk(ev, 6'h00, "stalled events");
        chk(irq, 1'b0, "stall irq");
        wr(OFS_GEN_CTL, 32'h1 | (32'h1 << GC_DBG_RUN));
        c = cnt;
        // stopped flag drops one edge before the count moves
        cyc(3);
        chk(cnt !== c, 1'b1, "keeps counting");
        i_debug_halt <= 1'b0;
        wr(OFS_GEN_CTL, 32'h0);
    endtask

    task automatic t_fault();
        i_fault <= 1'b1;
        cyc(5);
        chk(irq, 1'b1, "fault irq");
        rchk(OFS_FAULT_LVL, 32'h0000_0001);
        rchk(OFS_RAW_INT, 32'h0001_0000);
        i_fault <= 1'b0;
        cyc(5);
        rchk(OFS_FAULT_LVL, 32'h0);
        chk(irq, 1'b1, "latched");
        wr(OFS_INT_CLR, 32'h0001_0000);
        cyc(1);
        chk(irq, 1'b0, "fault cleared");
        rchk(OFS_INT_CLR, 32'h0);
    endtask

    initial begin
        cyc(10);
        i_rst <= 1'b0;
        t_map();
        t_pins();
        hold <= 1'b0;
        t_events(1'b0, 6'h03, 16);
        t_events(1'b1, 6'h01, 5);
        t_events(1'b1, 6'h0c, 10);
        t_update();
        t_stall();
        t_fault();
        summarize();
    end
endmodule
